// ==== core/tctr_consts.vh ====
/*
  shared constants of the tuning/temperature register block.
  assumes inclusion by bare name from files under core/.
*/
`ifndef TCTR_CONSTS_VH
`define TCTR_CONSTS_VH

`define TCTR_CODE_DIV 8'h5d
`define TCTR_CODE_CTRL 8'h60
`define TCTR_CODE_TEMP 8'h64
`define TCTR_CODE_TEMP_LO 8'h65
`define TCTR_CODE_TRIM 8'h66

`define TCTR_RST_BYTE 8'h00
`define TCTR_IDLE_BYTE 8'hff
`define TCTR_ADDR_HI 6'h24
`define TCTR_CTRL_DIV_OE 3
`define TCTR_CTRL_BASE_OE 2
`define TCTR_CTRL_HALVE 0
`define TCTR_LAST_BIT 3'h7
`define TCTR_TEMP_PAD 6'h00

`endif

// ==== core/tctr_divider.v ====
/*
  divided clock output generator.
  assumes base_rise marks each rising edge of the base output, same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tctr_divider #(
  parameter DW = 8
) (
  input wire ref_clk, // system clock
  input wire rst, // sync reset, active high
  input wire ce, // clock enable
  input wire base_rise, // one-cycle pulse per base period
  input wire base_level, // current base output level
  input wire [DW-1:0] div_n, // divider value n
  input wire halve_mode_bit, // 1: divide by 2(n+1)
  input wire enable, // output enable
  output reg div_q // divided output
);
  reg [DW-1:0] cnt_q;
  reg tog_q;
  wire wrap = (cnt_q >= div_n);

  always @(posedge ref_clk) begin
    if (rst) begin
      cnt_q <= {DW{1'b0}};
      tog_q <= 1'b0;
      div_q <= 1'b0;
    end else if (ce) begin
      if (base_rise) begin
        cnt_q <= wrap ? {DW{1'b0}} : cnt_q + {{(DW-1){1'b0}}, 1'b1};
        if (wrap)
          tog_q <= ~tog_q;
      end
      if (!enable)
        div_q <= 1'b0;
      else if (halve_mode_bit)
        div_q <= tog_q;
      else if (div_n == {DW{1'b0}})
        div_q <= base_level;
      else
        div_q <= (cnt_q == {DW{1'b0}});
    end
  end
endmodule
`default_nettype wire

// ==== core/tctr_regs.v ====
/*
  two-wire slave register layer of a tuned oscillator: code decode,
  divider/control/trim registers, temperature result, tuning sum.
  assumes scl/sda/address_select_pin are asynchronous pins; sensor and
  factory loading inputs are on ref_clk.
*/
// Operation
// - 8-bit trim register, resets zero, byte access
// - trim is two's complement loading offset
// - trim applied at next temperature update
// - each magnitude step about 0.08 ppm
// - bit 7 sets direction; 80h most negative
// - continuous 10-bit quarter-degree conversions
// - result holds latest conversion, reads harmless
// - high byte sign/integer, low byte fractions
// - 16-bit two's complement, MSB first, high first
// - code 64h reads one or two bytes
// - 5Dh divider, 60h control, one byte
// - 66h reaches trim register, one byte
// - pointer never advances; master resends code
// - second output divides by n+1 or 2(n+1)
// - control resets zero; enable and halve bits
// - address low bit from select pin
`timescale 1ns/1ps
`default_nettype none
`include "tctr_consts.vh"
module tctr_regs #(
  parameter DW = 8,
  parameter TW = 10
) (
  input wire ref_clk, // 20 MHz system clock
  input wire rst, // sync reset, active high
  input wire ce, // clock enable
  input wire scl_i, // bus clock pin
  input wire sda_i, // bus data pin level
  output reg sda_o_q, // bus data drive value, always 0
  output reg sda_oe_q, // high while pulling sda low
  input wire address_select_pin, // strapped address low bit
  input wire [TW-1:0] temp_sample, // finished conversion, quarter degrees
  input wire temp_done, // one-cycle pulse, conversion finished
  input wire [DW-1:0] factory_load, // factory-compensated loading
  output reg [DW+1:0] crystal_load_q, // signed loading setting
  output reg base_clock_output, // base output, gated
  output reg divided_clock_output // divided output, gated
);
  localparam S_IDLE = 7'h01;
  localparam S_ADDR = 7'h02;
  localparam S_ACK = 7'h04;
  localparam S_RX = 7'h08;
  localparam S_TX = 7'h10;
  localparam S_MACK = 7'h20;
  localparam S_WAIT = 7'h40;

  reg scl1_q, scl2_q, scl3_q, sda1_q, sda2_q, sda3_q, as1_q, as2_q;
  reg [6:0] st_q;
  reg [2:0] cnt_q;
  reg [7:0] sh_q, code_q, div_q, ctrl_q, trim_q, tx_hi_q, tx_lo_q;
  reg rd_q, addr_phase_q, code_phase_q, mack_q, idx_q, base_q;
  reg got8_q;
  reg [TW-1:0] temp_q;
  wire div_out;

  wire scl_rise = scl2_q & ~scl3_q;
  wire scl_fall = ~scl2_q & scl3_q;
  wire start_c = scl2_q & scl3_q & ~sda2_q & sda3_q;
  wire stop_c = scl2_q & scl3_q & sda2_q & ~sda3_q;
  wire [7:0] rx_byte = sh_q;
  wire known = (code_q == `TCTR_CODE_DIV) || (code_q == `TCTR_CODE_CTRL) ||
               (code_q == `TCTR_CODE_TEMP) || (code_q == `TCTR_CODE_TRIM);
  wire is_code = (rx_byte == `TCTR_CODE_DIV) || (rx_byte == `TCTR_CODE_CTRL) ||
                 (rx_byte == `TCTR_CODE_TEMP) || (rx_byte == `TCTR_CODE_TRIM);
  wire [15:0] temp_word = {temp_q, `TCTR_TEMP_PAD};

  reg [7:0] rd_byte;
  always @* begin
    case (code_q)
      `TCTR_CODE_DIV: rd_byte = div_q;
      `TCTR_CODE_CTRL: rd_byte = ctrl_q;
      `TCTR_CODE_TRIM: rd_byte = trim_q;
      `TCTR_CODE_TEMP: rd_byte = tx_hi_q;
      default: rd_byte = `TCTR_IDLE_BYTE;
    endcase
  end

  // second byte only exists for temperature; others repeat released bus
  wire [7:0] next_byte = (code_q == `TCTR_CODE_TEMP && !idx_q) ? tx_lo_q : `TCTR_IDLE_BYTE;

  always @(posedge ref_clk) begin
    if (rst) begin
      {scl1_q, scl2_q, scl3_q, sda1_q, sda2_q, sda3_q} <= 6'h3f;
      {as1_q, as2_q} <= 2'h0;
    end else if (ce) begin
      scl1_q <= scl_i;
      scl2_q <= scl1_q;
      scl3_q <= scl2_q;
      sda1_q <= sda_i;
      sda2_q <= sda1_q;
      sda3_q <= sda2_q;
      as1_q <= address_select_pin;
      as2_q <= as1_q;
    end
  end

  // temperature result and tuning sum, independent of bus activity
  always @(posedge ref_clk) begin
    if (rst) begin
      temp_q <= {TW{1'b0}};
      crystal_load_q <= {(DW+2){1'b0}};
    end else if (ce && temp_done) begin
      temp_q <= temp_sample;
      crystal_load_q <= {2'b00, factory_load} + {{2{trim_q[7]}}, trim_q};
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      base_q <= 1'b0;
      base_clock_output <= 1'b0;
      divided_clock_output <= 1'b0;
    end else if (ce) begin
      base_q <= ~base_q;
      base_clock_output <= ~base_q & ctrl_q[`TCTR_CTRL_BASE_OE];
      divided_clock_output <= div_out;
    end
  end

  tctr_divider #(.DW(DW)) u_div (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .base_rise(~base_q),
    .base_level(~base_q),
    .div_n(div_q),
    .halve_mode_bit(ctrl_q[`TCTR_CTRL_HALVE]),
    .enable(ctrl_q[`TCTR_CTRL_DIV_OE]),
    .div_q(div_out)
  );

  always @(posedge ref_clk) begin
    if (rst) begin
      st_q <= S_IDLE;
      cnt_q <= 3'h0;
      sh_q <= `TCTR_RST_BYTE;
      code_q <= `TCTR_RST_BYTE;
      div_q <= `TCTR_RST_BYTE;
      ctrl_q <= `TCTR_RST_BYTE;
      trim_q <= `TCTR_RST_BYTE;
      tx_hi_q <= `TCTR_RST_BYTE;
      tx_lo_q <= `TCTR_RST_BYTE;
      {rd_q, addr_phase_q, code_phase_q, mack_q, idx_q} <= 5'h00;
      got8_q <= 1'b0;
      sda_o_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (ce) begin
      if (start_c) begin
        st_q <= S_ADDR;
        cnt_q <= 3'h0;
        got8_q <= 1'b0;
        sda_oe_q <= 1'b0;
      end else if (stop_c) begin
        st_q <= S_IDLE;
        sda_oe_q <= 1'b0;
      end else begin
        case (st_q)
          S_IDLE: st_q <= S_IDLE;
          S_WAIT: st_q <= S_WAIT;
          S_ADDR, S_RX: begin
            if (scl_rise) begin
              sh_q <= {sh_q[6:0], sda2_q};
              cnt_q <= cnt_q + 3'h1;
              // counter wraps at eight; flag keeps the start's own scl fall from ending a byte
              if (cnt_q == `TCTR_LAST_BIT)
                got8_q <= 1'b1;
            end else if (scl_fall && got8_q) begin
              // eighth bit has been taken; decide the acknowledge
              got8_q <= 1'b0;
              if (st_q == S_ADDR) begin
                if (sh_q[7:1] == {`TCTR_ADDR_HI, as2_q}) begin
                  rd_q <= sh_q[0];
                  addr_phase_q <= 1'b1;
                  code_phase_q <= ~sh_q[0];
                  sda_oe_q <= 1'b1;
                  st_q <= S_ACK;
                  tx_hi_q <= temp_word[15:8];
                  tx_lo_q <= temp_word[7:0];
                end else
                  st_q <= S_WAIT;
              end else if (code_phase_q) begin
                code_q <= rx_byte;
                code_phase_q <= 1'b0;
                sda_oe_q <= is_code;
                st_q <= is_code ? S_ACK : S_WAIT;
              end else if (known && code_q != `TCTR_CODE_TEMP) begin
                if (code_q == `TCTR_CODE_DIV)
                  div_q <= rx_byte;
                if (code_q == `TCTR_CODE_CTRL)
                  ctrl_q <= rx_byte;
                if (code_q == `TCTR_CODE_TRIM)
                  trim_q <= rx_byte;
                sda_oe_q <= 1'b1;
                st_q <= S_ACK;
                code_phase_q <= 1'b0;
                code_q <= `TCTR_IDLE_BYTE;
              end else
                st_q <= S_WAIT;
            end
          end
          S_ACK: begin
            if (scl_fall) begin
              cnt_q <= 3'h0;
              idx_q <= 1'b0;
              if (addr_phase_q && rd_q) begin
                sh_q <= rd_byte;
                sda_oe_q <= ~rd_byte[7];
                st_q <= S_TX;
              end else begin
                sda_oe_q <= 1'b0;
                st_q <= S_RX;
              end
              addr_phase_q <= 1'b0;
            end
          end
          S_TX: begin
            if (scl_fall) begin
              if (cnt_q == `TCTR_LAST_BIT) begin
                sda_oe_q <= 1'b0;
                st_q <= S_MACK;
              end else begin
                sh_q <= {sh_q[6:0], 1'b0};
                sda_oe_q <= ~sh_q[6];
                cnt_q <= cnt_q + 3'h1;
              end
            end
          end
          S_MACK: begin
            if (scl_rise)
              mack_q <= ~sda2_q;
            else if (scl_fall) begin
              if (mack_q) begin
                sh_q <= next_byte;
                sda_oe_q <= ~next_byte[7];
                idx_q <= 1'b1;
                cnt_q <= 3'h0;
                st_q <= S_TX;
              end else
                st_q <= S_WAIT;
            end
          end
          default: st_q <= S_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ==== verification/tctr_monitor.sv ====
/* port checks of tctr_regs.
   assumes one ref_clk domain; bound below. */
`timescale 1ns/1ps
`default_nettype none
module tctr_monitor #(
  parameter DW = 8
) (
  input wire logic ref_clk, // clock
  input wire logic rst, // sync reset
  input wire logic ce, // clock enable
  input wire logic scl_i, // bus clock pin
  input wire logic sda_o_q, // drive value
  input wire logic sda_oe_q, // pulls sda
  input wire logic temp_done, // update pulse
  input wire logic [DW+1:0] crystal_load_q, // loading sum
  input wire logic base_clock_output, // base out
  input wire logic divided_clock_output // divided out
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  sequence s_up;
    $rose(sda_oe_q);
  endsequence
  sequence s_stand;
    sda_oe_q [*7];
  endsequence
  property p_rst;
    disable iff (1'b0) rst && ce |=> !sda_oe_q && crystal_load_q == '0
      && !base_clock_output && !divided_clock_output;
  endproperty
  property p_hold;
    !temp_done |=> $stable(crystal_load_q);
  endproperty
  property p_freeze;
    !ce |=> $stable(crystal_load_q) && $stable(sda_oe_q);
  endproperty
  property p_oe_low;
    $changed(sda_oe_q) |-> !scl_i;
  endproperty
  property p_stand;
    s_up |=> s_stand;
  endproperty
  property p_release;
    sda_oe_q |-> ##[1:200] !sda_oe_q;
  endproperty
  property p_base;
    $rose(base_clock_output) && ce |=> !base_clock_output;
  endproperty
  property p_low_only;
    sda_oe_q |-> sda_o_q == 1'b0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  a_hold: assert property (p_hold) else $error("load moved");
  a_freeze: assert property (p_freeze) else $error("ce low moved");
  a_oe_low: assert property (p_oe_low) else $error("sda moved, scl high");
  a_stand: assert property (p_stand) else $error("drive too short");
  a_release: assert property (p_release) else $error("sda held");
  a_base: assert property (p_base) else $error("base width");
  a_low_only: assert property (p_low_only) else $error("drove high");
endmodule
bind tctr_regs tctr_monitor #(.DW(DW)) u_mon (.ref_clk(ref_clk), .rst(rst), .ce(ce), .scl_i(scl_i),
  .sda_o_q(sda_o_q), .sda_oe_q(sda_oe_q), .temp_done(temp_done), .crystal_load_q(crystal_load_q),
  .base_clock_output(base_clock_output), .divided_clock_output(divided_clock_output));
`default_nettype wire

// ==== verification/tctr_master.sv ====
/* two-wire bus master model, timed by delays.
   assumes the bench resolves sda with a pull-up. */
`timescale 1ns/1ps
`default_nettype none
module tctr_master (
  output logic scl, // idles high
  output logic sda_m, // 0 pulls sda
  input wire logic sda, // resolved wire
  output logic [7:0] rd, // byte or ack seen
  output logic rd_stb // pulse per byte
);
  initial {scl, sda_m, rd, rd_stb} = 11'h600;
  task automatic bitx(input logic b, output logic r);
    #50 sda_m = b; // clear of the scl fall
    #150 scl = 1;
    #100 r = sda;
    #100 scl = 0;
  endtask
  task automatic start();
    #50 sda_m = 1;
    #150 scl = 1;
    #200 sda_m = 0;
    #200 scl = 0;
  endtask
  task automatic stop();
    #50 sda_m = 0;
    #150 scl = 1;
    #200 sda_m = 1;
    #200;
  endtask
  // strobe drop runs apart so bus timing keeps its 50 ns grid
  task automatic post(input logic [7:0] v);
    rd = v;
    rd_stb = 1;
    fork
      #1 rd_stb = 0;
    join_none
  endtask
  task automatic wbyte(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    post({7'h00, ~r});
  endtask
  task automatic rbyte(input logic last);
    logic [7:0] d;
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(last, r);
    post(d);
  endtask
endmodule
`default_nettype wire

// ==== verification/tctr_regs_tb.sv ====
/* self-checking bench of tctr_regs.
   assumes core/ on the include path. */
`timescale 1ns/1ps
`default_nettype none
`include "tctr_consts.vh"
module tctr_regs_tb;
  logic ref_clk, rst, ce, a0, temp_done, scl, sda_m, rd_stb, o, oe, base, div;
  logic [9:0] tsmp, ld, pl;
  logic [7:0] fl, rd, ad;
  logic [7:0] exp[$];
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  wire logic sda = sda_m & (oe ? o : 1'b1);
  tctr_master m (.scl(scl), .sda_m(sda_m), .sda(sda), .rd(rd), .rd_stb(rd_stb));
  tctr_regs dut (.ref_clk(ref_clk), .rst(rst), .ce(ce), .scl_i(scl), .sda_i(sda), .sda_o_q(o),
    .sda_oe_q(oe), .address_select_pin(a0), .temp_sample(tsmp), .temp_done(temp_done),
    .factory_load(fl), .crystal_load_q(ld), .base_clock_output(base), .divided_clock_output(div));
  initial begin
    ref_clk = 0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic chk(input string nm, input logic [9:0] s, input logic [9:0] e);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic print_verdict();
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 80000) begin
      fails++;
      print_verdict();
    end
  end
  always @(posedge rd_stb) chk("bus", {2'b00, rd}, {2'b00, exp.pop_front()});
  task automatic wb(input logic [7:0] d, input logic e);
    exp.push_back({7'h00, e});
    m.wbyte(d);
  endtask
  task automatic rb(input logic [7:0] e, input logic last);
    exp.push_back(e);
    m.rbyte(last);
  endtask
  task automatic wreg(input logic [7:0] c, input logic [7:0] d, input logic e);
    m.start();
    wb(ad, 1'b1);
    wb(c, e);
    if (e) wb(d, 1'b1);
    m.stop();
  endtask
  // code=0 reads without resending the code
  task automatic rreg(input logic [7:0] c, input logic [15:0] e, input logic two, input logic code);
    m.start();
    wb(ad, 1'b1);
    if (code) wb(c, 1'b1);
    m.start();
    wb(ad | 8'h01, 1'b1);
    rb(e[15:8], ~two);
    if (two) rb(e[7:0], 1'b1);
    m.stop();
  endtask
  task automatic upd(input logic [9:0] t);
    @(negedge ref_clk);
    tsmp = t;
    temp_done = 1;
    @(negedge ref_clk);
    temp_done = 0;
  endtask
  task automatic per(input logic [9:0] e);
    time t0;
    repeat (2) @(posedge div);
    t0 = $time;
    @(posedge div);
    chk("div", 10'(($time - t0) / 50), e);
    @(negedge ref_clk);
  endtask
  task automatic bper(input logic [9:0] e);
    time t0;
    @(posedge base);
    t0 = $time;
    @(posedge base);
    chk("base", 10'(($time - t0) / 50), e);
    @(negedge ref_clk);
  endtask
  initial begin
    logic [7:0] tab[6];
    logic [9:0] tt[5];
    void'($urandom(32'he898cf22));
    {rst, ce, temp_done, tsmp, pl} = 23'h600000;
    a0 = 1'($urandom);
    fl = 8'($urandom);
    ad = {`TCTR_ADDR_HI, a0, 1'b0};
    tab = '{8'h7f, 8'h80, 8'hff, 8'hb3, 8'($urandom), 8'h00};
    tt = '{10'h3fe, 10'h154, 10'h1ff, 10'h200, 10'($urandom)};
    repeat (4) @(negedge ref_clk);
    rst = 0;
    repeat (4) @(negedge ref_clk);
    chk("base", {9'h000, base}, 10'h000);
    chk("div", {9'h000, div}, 10'h000);
    rreg(8'h66, 16'h0000, 1'b0, 1'b1);
    rreg(8'h60, 16'h0000, 1'b0, 1'b1);
    foreach (tab[i]) begin
      wreg(8'h66, tab[i], 1'b1);
      rreg(8'h66, 16'hff00, 1'b0, 1'b0);
      rreg(8'h66, {tab[i], 8'h00}, 1'b0, 1'b1);
      chk("load", ld, pl);
      fl = 8'($urandom);
      upd(tsmp);
      pl = {2'b00, fl} + {{2{tab[i][7]}}, tab[i]};
      chk("load", ld, pl);
    end
    foreach (tt[i]) begin
      upd(tt[i]);
      rreg(8'h64, {tt[i], 6'h00}, 1'b1, 1'b1);
      rreg(8'h64, {tt[i], 6'h00}, 1'b0, 1'b1);
    end
    @(negedge ref_clk);
    ce = 0;
    upd(10'h0aa);
    ce = 1;
    chk("load", ld, pl);
    a0 = ~a0;
    ad = {`TCTR_ADDR_HI, a0, 1'b0};
    wreg(8'h61, 8'h00, 1'b0);
    m.start();
    wb(ad ^ 8'h02, 1'b0);
    m.stop();
    m.start();
    wb(ad, 1'b1);
    wb(8'h5d, 1'b1);
    wb(8'h01, 1'b1);
    wb(8'h07, 1'b0);
    m.stop();
    rreg(8'h5d, 16'h0100, 1'b0, 1'b1);
    wreg(8'h60, 8'h0c, 1'b1);
    per(10'd4);
    bper(10'd2);
    wreg(8'h60, 8'h0d, 1'b1);
    rreg(8'h60, 16'h0d00, 1'b0, 1'b1);
    per(10'd8);
    print_verdict();
  end
endmodule
`default_nettype wire
